// >>> rtl/analog_weight_output_pkg.sv
// shared constants for the analog weight output mapper
package analog_weight_output_pkg;
    localparam int unsigned CODE_WIDTH  = 16;
    localparam int unsigned VALUE_WIDTH = 24;

    // register offsets
    localparam logic [3:0] REG_CONTROL   = 4'h0;
    localparam logic [3:0] REG_MAXIMUM   = 4'h1;
    localparam logic [3:0] REG_ZERO_CODE = 4'h2;
    localparam logic [3:0] REG_HIGH_CODE = 4'h3;
    localparam logic [3:0] REG_LOW_FORCE = 4'h4;
    localparam logic [3:0] REG_HIGH_FORCE = 4'h5;
    localparam logic [3:0] REG_STATUS    = 4'h6;
    localparam logic [3:0] REG_CODE      = 4'h7;

    // control field positions
    localparam int unsigned CTRL_SOURCE_LSB  = 0;
    localparam int unsigned CTRL_VOLTAGE_BIT = 3;
    localparam int unsigned CTRL_RATE_EN_BIT = 4;
    localparam int unsigned CTRL_ENABLE_BIT  = 5;

    // status field positions
    localparam int unsigned STAT_FORCE_LOW_BIT  = 0;
    localparam int unsigned STAT_FORCE_HIGH_BIT = 1;
    localparam int unsigned STAT_SOURCE_OK_BIT  = 2;

    // source selections
    localparam logic [2:0] SRC_DISPLAYED      = 3'h0;
    localparam logic [2:0] SRC_ABS_DISPLAYED  = 3'h1;
    localparam logic [2:0] SRC_GROSS          = 3'h2;
    localparam logic [2:0] SRC_RATE           = 3'h3;
    localparam logic [2:0] SRC_ABSOLUTE_RATE_SOURCE       = 3'h4;

    // reset values: span 4 mA..20 mA, with 0 mA..24 mA mapped onto 0..ffff
    localparam logic [31:0] RESET_CONTROL    = 32'h0000_0000;
    localparam logic [23:0] RESET_MAXIMUM    = 24'h00_2710;
    localparam logic [15:0] RESET_ZERO_CODE  = 16'h2aaa;
    localparam logic [15:0] RESET_HIGH_CODE  = 16'hd555;
    localparam logic [15:0] RESET_LOW_FORCE  = 16'h0000;
    localparam logic [15:0] RESET_HIGH_FORCE = 16'hffff;
    localparam logic [15:0] RESET_CODE       = 16'h0000;
endpackage

// >>> rtl/analog_weight_output_mapper.sv
// maps a selected weighing value onto a 16-bit converter code
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module analog_weight_output_mapper #(
    parameter bit INTERNAL_VARIANT = 1'b0
) (
    input  wire logic                 clock,
    input  wire logic                 reset_n,
    input  wire logic [3:0]           address,
    input  wire logic [31:0]          write_data,
    input  wire logic                 write_strobe,
    input  wire logic                 read_strobe,
    output logic [31:0]               read_data,
    input  wire logic [23:0]          displayed_weight,
    input  wire logic [23:0]          gross_weight,
    input  wire logic                 weight_valid,
    input  wire logic                 blank_under,
    input  wire logic                 blank_over,
    input  wire logic                 gross_mode,
    input  wire logic [23:0]          rate_value,
    input  wire logic                 rate_valid,
    output logic [15:0]               converter_code,
    output logic                      converter_load,
    output logic                      voltage_mode
);

    typedef struct packed {
        logic [2:0]  source;
        logic        voltage;
        logic        rate_enable;
        logic        enable;
        logic [23:0] maximum;
        logic [15:0] zero_code;
        logic [15:0] high_code;
        logic [15:0] low_force;
        logic [15:0] high_force;
        logic        force_low;
        logic        force_high;
        logic [15:0] code;
        logic        load;
        logic [31:0] read_data;
    } state_t;

    state_t state;
    state_t next_state;

    function automatic logic [23:0] magnitude(input logic [23:0] v);
        magnitude = v[23] ? 24'(-v) : v;
    endfunction

    logic        rate_source;
    logic        abs_source;
    logic        source_ok;
    logic [23:0] raw;
    logic [23:0] value;
    logic        new_sample;
    logic        negative;
    logic        above;
    logic        want_low;
    logic        want_high;
    logic signed [17:0] span;
    logic signed [42:0] product;
    logic signed [42:0] scaled;
    logic signed [42:0] linear;
    logic [15:0] linear_code;

    always_comb begin
        rate_source = (state.source == analog_weight_output_pkg::SRC_RATE)
                   || (state.source == analog_weight_output_pkg::SRC_ABSOLUTE_RATE_SOURCE);
        abs_source  = (state.source == analog_weight_output_pkg::SRC_ABS_DISPLAYED)
                   || (state.source == analog_weight_output_pkg::SRC_ABSOLUTE_RATE_SOURCE);
        source_ok   = (state.source <= analog_weight_output_pkg::SRC_ABSOLUTE_RATE_SOURCE)
                   && (!rate_source || state.rate_enable);
        unique case (state.source)
            analog_weight_output_pkg::SRC_GROSS: raw = gross_weight;
            analog_weight_output_pkg::SRC_RATE,
            analog_weight_output_pkg::SRC_ABSOLUTE_RATE_SOURCE: raw = rate_value;
            default: raw = displayed_weight;
        endcase
        value      = abs_source ? magnitude(raw) : raw;
        new_sample = rate_source ? rate_valid : weight_valid;
        negative   = value[23];
        above      = !negative && (value > state.maximum);
        // extrapolation tracks past both ends until saturation for weight sources; rate forces below zero and above maximum, absolute rate above maximum only
        span    = 18'(signed'({2'b00, state.high_code}) - signed'({2'b00, state.zero_code}));
        product = 43'(signed'(value)) * 43'(span);
        scaled  = (state.maximum == 24'h00_0000) ? 43'sh0 : product / 43'(signed'({1'b0, state.maximum}));
        linear  = scaled + 43'(signed'({1'b0, state.zero_code}));
        unique case (state.source)
            analog_weight_output_pkg::SRC_RATE: begin
                want_low  = negative;
                want_high = above;
            end
            analog_weight_output_pkg::SRC_ABSOLUTE_RATE_SOURCE: begin
                want_low  = 1'b0;
                want_high = above;
            end
            analog_weight_output_pkg::SRC_ABS_DISPLAYED: begin
                want_low  = blank_under;
                want_high = gross_mode && (blank_over || linear > 43'sh0ffff);
            end
            default: begin
                want_low  = blank_under || linear < 43'sh0;
                want_high = blank_over || linear > 43'sh0ffff;
            end
        endcase
        // range checks still saturate the code so it never wraps
        if (linear < 43'sh0) begin
            linear_code = 16'h0000;
        end else if (linear > 43'sh0ffff) begin
            linear_code = 16'hffff;
        end else begin
            linear_code = linear[15:0];
        end
    end

    always_comb begin
        next_state      = state;
        next_state.load = 1'b0;
        if (write_strobe) begin
            unique case (address)
                analog_weight_output_pkg::REG_CONTROL: begin
                    next_state.source      = write_data[analog_weight_output_pkg::CTRL_SOURCE_LSB +: 3];
                    // the internal board has no voltage stage
                    next_state.voltage     = write_data[analog_weight_output_pkg::CTRL_VOLTAGE_BIT]
                                          && !INTERNAL_VARIANT;
                    next_state.rate_enable = write_data[analog_weight_output_pkg::CTRL_RATE_EN_BIT];
                    next_state.enable      = write_data[analog_weight_output_pkg::CTRL_ENABLE_BIT];
                end
                analog_weight_output_pkg::REG_MAXIMUM:    next_state.maximum    = write_data[23:0];
                analog_weight_output_pkg::REG_ZERO_CODE:  next_state.zero_code  = write_data[15:0];
                analog_weight_output_pkg::REG_HIGH_CODE:  next_state.high_code  = write_data[15:0];
                analog_weight_output_pkg::REG_LOW_FORCE:  next_state.low_force  = write_data[15:0];
                analog_weight_output_pkg::REG_HIGH_FORCE: next_state.high_force = write_data[15:0];
                default: ;
            endcase
        end
        if (state.enable && source_ok && new_sample) begin
            // flags move only on a fresh sample, so release waits for the next update
            next_state.force_low  = want_low;
            next_state.force_high = want_high && !want_low;
            if (want_low) begin
                next_state.code = state.low_force;
            end else if (want_high) begin
                next_state.code = state.high_force;
            end else begin
                next_state.code = linear_code;
            end
            next_state.load = 1'b1;
        end
        next_state.read_data = 32'h0000_0000;
        if (read_strobe) begin
            unique case (address)
                analog_weight_output_pkg::REG_CONTROL: next_state.read_data =
                    {26'h0, state.enable, state.rate_enable, state.voltage, state.source};
                analog_weight_output_pkg::REG_MAXIMUM:    next_state.read_data = {8'h00, state.maximum};
                analog_weight_output_pkg::REG_ZERO_CODE:  next_state.read_data = {16'h0000, state.zero_code};
                analog_weight_output_pkg::REG_HIGH_CODE:  next_state.read_data = {16'h0000, state.high_code};
                analog_weight_output_pkg::REG_LOW_FORCE:  next_state.read_data = {16'h0000, state.low_force};
                analog_weight_output_pkg::REG_HIGH_FORCE: next_state.read_data = {16'h0000, state.high_force};
                analog_weight_output_pkg::REG_STATUS:     next_state.read_data =
                    {29'h0, source_ok, state.force_high, state.force_low};
                analog_weight_output_pkg::REG_CODE:       next_state.read_data = {16'h0000, state.code};
                default: next_state.read_data = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state.source      <= analog_weight_output_pkg::RESET_CONTROL[2:0];
            state.voltage     <= 1'b0;
            state.rate_enable <= 1'b0;
            state.enable      <= 1'b0;
            state.maximum     <= analog_weight_output_pkg::RESET_MAXIMUM;
            state.zero_code   <= analog_weight_output_pkg::RESET_ZERO_CODE;
            state.high_code   <= analog_weight_output_pkg::RESET_HIGH_CODE;
            state.low_force   <= analog_weight_output_pkg::RESET_LOW_FORCE;
            state.high_force  <= analog_weight_output_pkg::RESET_HIGH_FORCE;
            state.force_low   <= 1'b0;
            state.force_high  <= 1'b0;
            state.code        <= analog_weight_output_pkg::RESET_CODE;
            state.load        <= 1'b0;
            state.read_data   <= 32'h0000_0000;
        end else begin
            state <= next_state;
        end
    end

    assign read_data      = state.read_data;
    assign converter_code = state.code;
    assign converter_load = state.load;
    assign voltage_mode   = state.voltage;

endmodule

`default_nettype wire

// >>> sim/awom_checker_asserts.sv
// port checker for the analog weight output mapper
`timescale 1ns/100ps
`default_nettype none
module awom_checker #(parameter bit INTERNAL_VARIANT = 1'b0) (
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic [3:0]  address,
    input wire logic [31:0] write_data,
    input wire logic        write_strobe,
    input wire logic        read_strobe,
    input wire logic [31:0] read_data,
    input wire logic        weight_valid,
    input wire logic        rate_valid,
    input wire logic [15:0] converter_code,
    input wire logic        converter_load,
    input wire logic        voltage_mode
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    wire logic ctl_wr = write_strobe && address == 4'h0;
    rd_idle_a: assert property (!$past(read_strobe) |-> read_data == 32'h0)
        else $error("read data not idle");
    code_read_a: assert property ($past(read_strobe && address == 4'h7) |-> read_data == {16'h0, $past(converter_code)})
        else $error("code readback wrong");
    unmapped_a: assert property ($past(read_strobe && address[3]) |-> read_data == 32'h0)
        else $error("unmapped read not zero");
    status_read_a: assert property ($past(read_strobe && address == 4'h6) |-> read_data[31:3] == 29'h0)
        else $error("status upper bits set");
    load_cause_a: assert property (converter_load |-> $past(weight_valid || rate_valid))
        else $error("load without new value");
    code_hold_a: assert property (!converter_load |-> $stable(converter_code))
        else $error("code moved without load");
    volt_follow_a: assert property (ctl_wr |=> voltage_mode == ($past(write_data[3]) && !INTERNAL_VARIANT))
        else $error("voltage mode not written");
    volt_hold_a: assert property (!ctl_wr |=> $stable(voltage_mode))
        else $error("voltage mode moved");
    off_refuse_a: assert property (ctl_wr && !write_data[5] ##[1:3] (weight_valid || rate_valid) |=> !converter_load)
        else $error("load while disabled");
    cover property (converter_load && converter_code == 16'hffff);
    cover property (converter_load && converter_code == 16'h0000);
    cover property (read_strobe && address == 4'h7);
endmodule
bind analog_weight_output_mapper awom_checker #(.INTERNAL_VARIANT(INTERNAL_VARIANT)) u_chk (.clock(clock),
    .reset_n(reset_n), .address(address), .write_data(write_data), .write_strobe(write_strobe),
    .read_strobe(read_strobe), .read_data(read_data), .weight_valid(weight_valid), .rate_valid(rate_valid),
    .converter_code(converter_code), .converter_load(converter_load), .voltage_mode(voltage_mode));
`default_nettype wire

// >>> sim/dac_stage_model.sv
// behavioural d/a stage that latches each loaded code
`timescale 1ns/100ps
`default_nettype none
module dac_stage_model (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic [15:0] converter_code,
    input  wire logic        converter_load,
    input  wire logic        voltage_mode,
    output logic      [15:0] level,
    output logic             volt_out
);
    // the stage only takes the word on the load pulse, so a stray code change stays invisible
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            level <= 16'h0000;
            volt_out <= 1'b0;
        end else begin
            if (converter_load) level <= converter_code;
            volt_out <= voltage_mode;
        end
    end
endmodule
`default_nettype wire

// >>> sim/analog_weight_output_mapper_test.sv
// self-checking bench for the analog weight output mapper
`timescale 1ns/100ps
`default_nettype none
module analog_weight_output_mapper_test;
    logic clock = 1'b0, reset_n = 1'b0, write_strobe = 1'b0, read_strobe = 1'b0, rd_seen = 1'b0;
    logic weight_valid = 1'b0, rate_valid = 1'b0, blank_under = 1'b0, blank_over = 1'b0, gross_mode = 1'b0;
    logic [3:0]  address = '0;
    logic [31:0] write_data = '0;
    logic [23:0] displayed_weight = '0, gross_weight = '0, rate_value = '0;
    wire logic [31:0] read_data;
    wire logic [15:0] converter_code, level;
    wire logic converter_load, voltage_mode, volt_out;
    int err_total = 0, comparisons = 0;
    longint sh[6] = '{64'h0, 64'h2710, 64'h2aaa, 64'hd555, 64'h0, 64'hffff};
    logic [31:0] rq[$];
    logic [15:0] cq[$];
    // a single output instance only; both at once is not a supported setup
    analog_weight_output_mapper i_dut (.clock(clock), .reset_n(reset_n), .address(address),
        .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
        .displayed_weight(displayed_weight), .gross_weight(gross_weight), .weight_valid(weight_valid),
        .blank_under(blank_under), .blank_over(blank_over), .gross_mode(gross_mode), .rate_value(rate_value),
        .rate_valid(rate_valid), .converter_code(converter_code), .converter_load(converter_load),
        .voltage_mode(voltage_mode));
    dac_stage_model i_dac (.clock(clock), .reset_n(reset_n), .converter_code(converter_code),
        .converter_load(converter_load), .voltage_mode(voltage_mode), .level(level), .volt_out(volt_out));
    initial forever #5 clock = ~clock;
    task automatic chk_word(input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_code(input logic [15:0] got, exp);
        chk_word({16'h0, got}, {16'h0, exp});
    endtask
    task automatic stop_test;
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
        if (a < 4'h6) sh[a] = (a == 4'h1) ? d[23:0] : d[15:0];
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clock);
        address <= a;
        read_strobe <= 1'b1;
        rq.push_back(e);
        @(posedge clock);
        read_strobe <= 1'b0;
    endtask
    // sample with expected force flags; magnitude taken for the absolute sources
    task automatic put(input logic [23:0] v, input bit lo, hi, e);
        longint m, l;
        bit rt;
        rt = sh[0][2:0] inside {3'h3, 3'h4};
        m = longint'(signed'(v));
        if (sh[0][2:0] inside {3'h1, 3'h4} && m < 0) m = -m;
        l = sh[2] + m * (sh[3] - sh[2]) / sh[1];
        @(posedge clock);
        displayed_weight <= sh[0][1] ? 24'($urandom) : v;
        gross_weight <= sh[0][1] ? v : 24'($urandom);
        rate_value <= v;
        weight_valid <= !rt;
        rate_valid <= rt;
        if (e) cq.push_back((lo || l < 0) ? sh[4][15:0] : (hi || l > 64'hffff) ? sh[5][15:0] : l[15:0]);
        @(posedge clock);
        weight_valid <= 1'b0;
        rate_valid <= 1'b0;
    endtask
    always @(posedge clock) begin
        rd_seen <= read_strobe;
        #1;
        if (rd_seen) chk_word(read_data, rq.size() ? rq.pop_front() : 32'hx);
        if (converter_load === 1'b1) chk_code(converter_code, cq.size() ? cq.pop_front() : 16'hx);
    end
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        stop_test;
    end
    initial begin
        void'($urandom(32'h4150));
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        for (int i = 0; i < 6; i++) rd(4'(i), 32'(sh[i]));
        wr(4'h7, 32'h1234);
        rd(4'h7, 32'h0);
        rd(4'hc, 32'h0);
        $display("register map test done");
        wr(4'h0, 32'h20);
        put(24'h0, 0, 0, 1);
        put(24'h2710, 0, 0, 1);
        put(24'h1388, 0, 0, 1);
        repeat (4) put(24'($urandom_range(32'h2710)), 0, 0, 1);
        put(24'hffff9c, 0, 0, 1);
        put(24'hffd8f0, 0, 0, 1);
        put(24'h4e20, 0, 0, 1);
        blank_under <= 1'b1;
        put(24'h64, 1, 0, 1);
        blank_under <= 1'b0;
        blank_over <= 1'b1;
        put(24'h64, 0, 1, 1);
        blank_over <= 1'b0;
        put(24'h64, 0, 0, 1);
        $display("displayed source test done");
        wr(4'h0, 32'h21);
        put(24'hffec78, 0, 0, 1);
        blank_under <= 1'b1;
        put(24'hffec78, 1, 0, 1);
        blank_under <= 1'b0;
        blank_over <= 1'b1;
        put(24'h64, 0, 0, 1);
        gross_mode <= 1'b1;
        put(24'h64, 0, 1, 1);
        gross_mode <= 1'b0;
        blank_over <= 1'b0;
        wr(4'h0, 32'h22);
        put(24'hbb8, 0, 0, 1);
        wr(4'h0, 32'h0);
        put(24'h64, 0, 0, 0);
        wr(4'h0, 32'h25);
        put(24'h64, 0, 0, 0);
        $display("source select test done");
        wr(4'h0, 32'h23);
        put(24'h64, 0, 0, 0);
        wr(4'h0, 32'h33);
        @(posedge clock);
        weight_valid <= 1'b1;
        @(posedge clock);
        weight_valid <= 1'b0;
        put(24'h1f4, 0, 0, 1);
        put(24'hffffff, 1, 0, 1);
        put(24'h2711, 0, 1, 1);
        put(24'h64, 0, 0, 1);
        wr(4'h0, 32'h34);
        put(24'hffec78, 0, 0, 1);
        put(24'hffd8ef, 0, 1, 1);
        $display("rate test done");
        wr(4'h0, 32'h28);
        #1 chk_word({31'h0, voltage_mode}, 32'h1);
        // scale capacity (maximum) stands before the zero and high codes are adjusted
        wr(4'h2, 32'h1000);
        wr(4'h3, 32'hc000);
        wr(4'h4, 32'h0f00);
        wr(4'h5, 32'hf800);
        put(24'h2710, 0, 0, 1);
        blank_under <= 1'b1;
        put(24'h64, 1, 0, 1);
        blank_under <= 1'b0;
        blank_over <= 1'b1;
        put(24'h64, 0, 1, 1);
        rd(4'h6, 32'h6);
        rd(4'h2, 32'h1000);
        $display("voltage and calibration test done");
        for (int i = 0; i < 20 && (cq.size() || rq.size()); i++) @(posedge clock);
        if (cq.size() || rq.size()) err_total++;
        chk_code(level, 16'hf800);
        chk_word({31'h0, volt_out}, 32'h1);
        stop_test;
    end
endmodule
`default_nettype wire
